// ### common/ccrb_pkg.sv
// Package for the charger control register bank: offsets, field positions,
// power-up values and timing counts.
// Assumes a 10 MHz core clock.
package ccrb_pkg;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h05;
  localparam logic [7:0] OFS_INPUT_CFG = 8'h06;
  localparam logic [7:0] OFS_BATSW_CTRL = 8'h07;
  // Power-up values
  localparam logic [7:0] RST_TIMER_CTRL = 8'h9F;
  localparam logic [7:0] RST_INPUT_CFG = 8'h66;
  localparam logic [7:0] RST_BATSW_CTRL = 8'h4C;
  // Bits restored by watchdog expiry in the third register
  localparam logic [7:0] WDOG_MASK_BATSW = 8'hD4;
  // Field positions, charge timer control
  localparam int TERM_EN_BIT = 7;
  localparam int PROT_DIS_BIT = 6;
  localparam int WDOG_HI_BIT = 5;
  localparam int WDOG_LO_BIT = 4;
  localparam int SAFE_EN_BIT = 3;
  localparam int SAFE_DUR_BIT = 2;
  localparam int THERM_BIT = 1;
  localparam int COOL_BIT = 0;
  // Field positions, input protection config
  localparam int VLIM_HI_BIT = 3;
  localparam int VLIM_LO_BIT = 0;
  // Field positions, battery switch control
  localparam int DETECT_BIT = 7;
  localparam int SLOW_BIT = 6;
  localparam int BSW_DIS_BIT = 5;
  localparam int WARM_BIT = 4;
  localparam int BSW_DLY_BIT = 3;
  localparam int BSW_RST_BIT = 2;
  localparam int TRACK_HI_BIT = 1;
  localparam int TRACK_LO_BIT = 0;
  // Threshold arithmetic in millivolts
  localparam logic [15:0] VLIM_BASE_MV = 16'h0F3C;
  localparam logic [15:0] VLIM_STEP_MV = 16'h0064;
  localparam logic [15:0] TRACK1_MV = 16'h00C8;
  localparam logic [15:0] TRACK2_MV = 16'h00FA;
  localparam logic [15:0] TRACK3_MV = 16'h012C;
  localparam logic [15:0] WARM_MAX_MV = 16'h1004;
  // Timing
  localparam longint CLK_HZ = 10000000;
  localparam longint WDOG_BASE_S = 40;
  localparam longint BSW_DLY_S = 10;
  localparam longint WDOG_BASE_CYC = WDOG_BASE_S * CLK_HZ;
  localparam longint BSW_DLY_CYC = BSW_DLY_S * CLK_HZ;
  localparam int SAFE_SHORT_H = 5;
  localparam int SAFE_LONG_H = 10;
endpackage : ccrb_pkg

// ### logic/ccrb_wdog.sv
// Host watchdog: counts the selected period, restarted by each host write.
// Assumes the period select comes from a register on the same clock.
`timescale 1ns/100ps
module ccrb_wdog #(
  parameter logic [31:0] BASE_CYC = 32'd400000000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] period_sel,
  input wire logic kick,
  output logic expire
);
  logic [33:0] count_reg;
  logic [33:0] limit;

  always_comb begin
    unique case (period_sel)
      2'h1: limit = {2'h0, BASE_CYC};
      2'h2: limit = {1'h0, BASE_CYC, 1'h0};
      2'h3: limit = {BASE_CYC, 2'h0};
      default: limit = 34'h0;
    endcase
  end

  // Disabled period holds the count idle
  always_ff @(posedge clk) begin
    if (!rst_b || kick || period_sel == 2'h0 || expire) begin
      count_reg <= 34'h0;
    end else begin
      count_reg <= count_reg + 34'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      expire <= 1'b0;
    end else begin
      expire <= !kick && period_sel != 2'h0 && !expire && count_reg + 34'h1 >= limit;
    end
  end

  a_no_expire_off: assert property (@(posedge clk) disable iff (!rst_b)
    period_sel == 2'h0 && $past(period_sel) == 2'h0 |-> !expire)
    else $error("watchdog expired while disabled");
endmodule : ccrb_wdog

// ### logic/ccrb_top.sv
// Charger control register bank: three control registers written by the
// host over the serial link, with derived controls for the charger core.
// Assumes register strobes are already in the clk domain; pin inputs are not.
`timescale 1ns/100ps
// Overview of operation
// - Bit 7 of the first register enables termination; powers up set.
// - Protection switch disable acts only while high-impedance mode is on.
// - Watchdog field: off, 40 s, 80 s, 160 s; powers up at 40 s.
// - Safety timer enable gates fast-charge and precharge timers together; default on.
// - Safety timer duration bit: 5 h cleared, 10 h set; default 10 h.
// - Input voltage limit is 3.9 V plus 100 mV per code; default 0110.
// - Writing one to detection force starts data-line detection; default zero.
// - Power-select variant reads the pin level on the detection force bit.
// - Slow-down bit halves safety timer rate in limiting, cool band, thermal loop.
// - Battery switch disable set turns the switch off after the chosen delay.
// - Delay bit: immediate turn-off cleared, about 10 s set; default set.
// - Warm band limits charge voltage to 4.1 V unless warm select set.
// - Battery switch reset enable turns the reset function on; powers up set.
// - Tracking offset is off or adds 200/250/300 mV to battery; limit is the higher.
// - Register reset restores all; watchdog restores listed fields only.
module ccrb_top #(
  parameter logic [31:0] WDOG_BASE_CYC = 32'(ccrb_pkg::WDOG_BASE_CYC),
  parameter logic [31:0] BSW_DLY_CYC = 32'(ccrb_pkg::BSW_DLY_CYC),
  parameter logic PSEL_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic soft_reg_reset,
  input wire logic power_select_pin,
  input wire logic high_impedance_mode,
  input wire logic in_input_limit,
  input wire logic in_cool_band,
  input wire logic in_warm_band,
  input wire logic in_thermal_reg,
  input wire logic detect_done,
  input wire logic [15:0] battery_mv,
  input wire logic [15:0] charge_voltage_mv,
  output logic [7:0] reg_rdata,
  output logic termination_enable,
  output logic input_protect_switch_off,
  output logic fast_timer_enable,
  output logic precharge_timer_enable,
  output logic [3:0] safety_timer_hours,
  output logic safety_timer_half_rate,
  output logic thermal_regulation_threshold,
  output logic cool_current_select,
  output logic [1:0] input_overvoltage_threshold,
  output logic [1:0] boost_voltage_select,
  output logic [15:0] input_voltage_limit_mv,
  output logic detection_start,
  output logic detection_active,
  output logic battery_switch_on,
  output logic [15:0] charge_voltage_limit_mv,
  output logic battery_switch_reset_enable,
  output logic watchdog_expired
);
  logic [7:0] timer_ctrl_reg;
  logic [7:0] input_cfg_reg;
  logic [7:0] batsw_ctrl_reg;
  logic wdog_expire;
  logic psel_meta_reg;
  logic psel_sync_reg;
  logic detect_pend_reg;
  logic [31:0] bsw_count_reg;
  logic reg_init;
  logic wr_timer;
  logic wr_input;
  logic wr_batsw;
  logic [15:0] vlim_reg_mv;
  logic [15:0] track_mv;
  logic [15:0] track_sum_mv;
  logic [15:0] vlim_next;

  assign reg_init = !rst_b || soft_reg_reset;
  assign wr_timer = reg_wr && reg_addr == ccrb_pkg::OFS_TIMER_CTRL;
  assign wr_input = reg_wr && reg_addr == ccrb_pkg::OFS_INPUT_CFG;
  assign wr_batsw = reg_wr && reg_addr == ccrb_pkg::OFS_BATSW_CTRL;

  ccrb_wdog #(
    .BASE_CYC(WDOG_BASE_CYC)
  ) u_wdog (
    .clk(clk),
    .rst_b(rst_b),
    .period_sel(timer_ctrl_reg[ccrb_pkg::WDOG_HI_BIT:ccrb_pkg::WDOG_LO_BIT]),
    .kick(reg_wr || soft_reg_reset),
    .expire(wdog_expire)
  );

  // Power-select pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      psel_meta_reg <= 1'b0;
      psel_sync_reg <= 1'b0;
    end else begin
      psel_meta_reg <= power_select_pin;
      psel_sync_reg <= psel_meta_reg;
    end
  end

  // First register: every field also restored by watchdog expiry
  always_ff @(posedge clk) begin
    if (reg_init || wdog_expire) begin
      timer_ctrl_reg <= ccrb_pkg::RST_TIMER_CTRL;
    end else if (wr_timer) begin
      timer_ctrl_reg <= reg_wdata;
    end
  end

  // Second register: only register reset restores it
  always_ff @(posedge clk) begin
    if (reg_init) begin
      input_cfg_reg <= ccrb_pkg::RST_INPUT_CFG;
    end else if (wr_input) begin
      input_cfg_reg <= reg_wdata;
    end
  end

  // Third register: watchdog restores only the masked fields
  always_ff @(posedge clk) begin
    if (reg_init) begin
      batsw_ctrl_reg <= ccrb_pkg::RST_BATSW_CTRL;
    end else if (wr_batsw) begin
      batsw_ctrl_reg <= reg_wdata;
      batsw_ctrl_reg[ccrb_pkg::DETECT_BIT] <= 1'b0;
    end else if (wdog_expire) begin
      batsw_ctrl_reg <= (batsw_ctrl_reg & ~ccrb_pkg::WDOG_MASK_BATSW)
        | (ccrb_pkg::RST_BATSW_CTRL & ccrb_pkg::WDOG_MASK_BATSW);
    end
  end

  // Detection runs until the detector reports done or the watchdog expires; a new request wins
  // A host write also beats a same-cycle watchdog expiry, as the register does
  always_ff @(posedge clk) begin
    if (reg_init) begin
      detect_pend_reg <= 1'b0;
    end else if (wr_batsw && reg_wdata[ccrb_pkg::DETECT_BIT]) begin
      detect_pend_reg <= 1'b1;
    end else if (detect_done || wdog_expire) begin
      detect_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      detection_start <= 1'b0;
    end else begin
      detection_start <= wr_batsw && reg_wdata[ccrb_pkg::DETECT_BIT] && !soft_reg_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      detection_active <= 1'b0;
    end else begin
      detection_active <= detect_pend_reg;
    end
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ccrb_pkg::OFS_TIMER_CTRL: reg_rdata <= timer_ctrl_reg;
        ccrb_pkg::OFS_INPUT_CFG: reg_rdata <= input_cfg_reg;
        ccrb_pkg::OFS_BATSW_CTRL: begin
          reg_rdata <= batsw_ctrl_reg;
          reg_rdata[ccrb_pkg::DETECT_BIT] <= PSEL_VARIANT ? psel_sync_reg
            : detect_pend_reg;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Simple decoded controls
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      termination_enable <= 1'b1;
      input_protect_switch_off <= 1'b0;
      fast_timer_enable <= 1'b1;
      precharge_timer_enable <= 1'b1;
      safety_timer_hours <= 4'(ccrb_pkg::SAFE_LONG_H);
      safety_timer_half_rate <= 1'b0;
      thermal_regulation_threshold <= 1'b1;
      cool_current_select <= 1'b1;
      input_overvoltage_threshold <= 2'h1;
      boost_voltage_select <= 2'h2;
      battery_switch_reset_enable <= 1'b1;
      watchdog_expired <= 1'b0;
    end else begin
      termination_enable <= timer_ctrl_reg[ccrb_pkg::TERM_EN_BIT];
      input_protect_switch_off <= timer_ctrl_reg[ccrb_pkg::PROT_DIS_BIT]
        && high_impedance_mode;
      fast_timer_enable <= timer_ctrl_reg[ccrb_pkg::SAFE_EN_BIT];
      precharge_timer_enable <= timer_ctrl_reg[ccrb_pkg::SAFE_EN_BIT];
      safety_timer_hours <= timer_ctrl_reg[ccrb_pkg::SAFE_DUR_BIT]
        ? 4'(ccrb_pkg::SAFE_LONG_H) : 4'(ccrb_pkg::SAFE_SHORT_H);
      safety_timer_half_rate <= batsw_ctrl_reg[ccrb_pkg::SLOW_BIT]
        && (in_input_limit || in_cool_band || in_thermal_reg);
      thermal_regulation_threshold <= timer_ctrl_reg[ccrb_pkg::THERM_BIT];
      cool_current_select <= timer_ctrl_reg[ccrb_pkg::COOL_BIT];
      input_overvoltage_threshold <= input_cfg_reg[7:6];
      boost_voltage_select <= input_cfg_reg[5:4];
      battery_switch_reset_enable <= batsw_ctrl_reg[ccrb_pkg::BSW_RST_BIT];
      watchdog_expired <= wdog_expire;
    end
  end

  // Battery switch turn-off delay; clearing the disable bit aborts it
  always_ff @(posedge clk) begin
    if (!rst_b || !batsw_ctrl_reg[ccrb_pkg::BSW_DIS_BIT]) begin
      bsw_count_reg <= 32'h0;
    end else if (bsw_count_reg < BSW_DLY_CYC) begin
      bsw_count_reg <= bsw_count_reg + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      battery_switch_on <= 1'b1;
    end else if (!batsw_ctrl_reg[ccrb_pkg::BSW_DIS_BIT]) begin
      battery_switch_on <= 1'b1;
    end else if (!batsw_ctrl_reg[ccrb_pkg::BSW_DLY_BIT]
        || bsw_count_reg >= BSW_DLY_CYC) begin
      battery_switch_on <= 1'b0;
    end
  end

  // Effective input voltage limit
  always_comb begin
    vlim_reg_mv = ccrb_pkg::VLIM_BASE_MV + 16'(ccrb_pkg::VLIM_STEP_MV
      * input_cfg_reg[ccrb_pkg::VLIM_HI_BIT:ccrb_pkg::VLIM_LO_BIT]);
    unique case (batsw_ctrl_reg[ccrb_pkg::TRACK_HI_BIT:ccrb_pkg::TRACK_LO_BIT])
      2'h0: track_mv = 16'h0;
      2'h1: track_mv = ccrb_pkg::TRACK1_MV;
      2'h2: track_mv = ccrb_pkg::TRACK2_MV;
      2'h3: track_mv = ccrb_pkg::TRACK3_MV;
    endcase
    track_sum_mv = battery_mv + track_mv;
    if (track_mv != 16'h0 && track_sum_mv > vlim_reg_mv) begin
      vlim_next = track_sum_mv;
    end else begin
      vlim_next = vlim_reg_mv;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      input_voltage_limit_mv <= 16'h1194;
      charge_voltage_limit_mv <= 16'h0000;
    end else begin
      input_voltage_limit_mv <= vlim_next;
      if (in_warm_band && !batsw_ctrl_reg[ccrb_pkg::WARM_BIT]
          && charge_voltage_mv > ccrb_pkg::WARM_MAX_MV) begin
        charge_voltage_limit_mv <= ccrb_pkg::WARM_MAX_MV;
      end else begin
        charge_voltage_limit_mv <= charge_voltage_mv;
      end
    end
  end

  a_term_follows: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 termination_enable == $past(timer_ctrl_reg[ccrb_pkg::TERM_EN_BIT]))
    else $error("termination enable mismatch");
  a_prot_gated: assert property (@(posedge clk) disable iff (!rst_b)
    input_protect_switch_off |-> $past(high_impedance_mode))
    else $error("protection switch off without high impedance");
  a_timers_paired: assert property (@(posedge clk) disable iff (!rst_b)
    fast_timer_enable == precharge_timer_enable)
    else $error("safety timers disagree");
  a_timer_hours: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (safety_timer_hours == 4'(ccrb_pkg::SAFE_LONG_H))
      == $past(timer_ctrl_reg[ccrb_pkg::SAFE_DUR_BIT]))
    else $error("timer hours mismatch");
  a_soft_reset_vals: assert property (@(posedge clk) disable iff (!rst_b)
    soft_reg_reset |=> timer_ctrl_reg == ccrb_pkg::RST_TIMER_CTRL
      && input_cfg_reg == ccrb_pkg::RST_INPUT_CFG
      && batsw_ctrl_reg == ccrb_pkg::RST_BATSW_CTRL)
    else $error("register reset values wrong");
  a_wdog_restore: assert property (@(posedge clk) disable iff (!rst_b)
    wdog_expire |=> timer_ctrl_reg == ccrb_pkg::RST_TIMER_CTRL)
    else $error("watchdog left timer control");
  a_wdog_keeps_input: assert property (@(posedge clk) disable iff (!rst_b)
    wdog_expire && !soft_reg_reset && !wr_input |=> $stable(input_cfg_reg))
    else $error("watchdog altered input config");
  a_wdog_keeps_bsw: assert property (@(posedge clk) disable iff (!rst_b)
    wdog_expire && !reg_init && !wr_batsw
      |=> $stable(batsw_ctrl_reg & ~ccrb_pkg::WDOG_MASK_BATSW))
    else $error("watchdog altered switch fields");
  a_write_readback: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == ccrb_pkg::OFS_INPUT_CFG
      |=> reg_rdata == $past(input_cfg_reg))
    else $error("read back differs");
  a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    wr_input && !soft_reg_reset |=> input_cfg_reg == $past(reg_wdata))
    else $error("write did not land");
  a_pin_readback: assert property (@(posedge clk) disable iff (!rst_b)
    PSEL_VARIANT && reg_rd && reg_addr == ccrb_pkg::OFS_BATSW_CTRL
      |=> reg_rdata[ccrb_pkg::DETECT_BIT] == $past(psel_sync_reg))
    else $error("pin level not read back");
  a_bsw_immediate: assert property (@(posedge clk) disable iff (!rst_b)
    batsw_ctrl_reg[ccrb_pkg::BSW_DIS_BIT] && !batsw_ctrl_reg[ccrb_pkg::BSW_DLY_BIT]
      |=> !battery_switch_on)
    else $error("battery switch not off at once");
  a_bsw_wait: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(batsw_ctrl_reg[ccrb_pkg::BSW_DIS_BIT]) && batsw_ctrl_reg[ccrb_pkg::BSW_DLY_BIT]
      |=> battery_switch_on)
    else $error("battery switch cut early");
  a_bsw_allow: assert property (@(posedge clk) disable iff (!rst_b)
    !batsw_ctrl_reg[ccrb_pkg::BSW_DIS_BIT] |=> battery_switch_on)
    else $error("battery switch held off");
  a_warm_clamp: assert property (@(posedge clk) disable iff (!rst_b)
    in_warm_band && !batsw_ctrl_reg[ccrb_pkg::WARM_BIT]
      |=> charge_voltage_limit_mv <= ccrb_pkg::WARM_MAX_MV)
    else $error("warm charge voltage above limit");
  a_rst_en_follows: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 battery_switch_reset_enable == $past(batsw_ctrl_reg[ccrb_pkg::BSW_RST_BIT]))
    else $error("switch reset enable mismatch");
  a_detect_start: assert property (@(posedge clk) disable iff (!rst_b)
    wr_batsw && reg_wdata[ccrb_pkg::DETECT_BIT] && !soft_reg_reset
      |=> detection_start ##1 detection_active)
    else $error("detection not started");
  a_half_rate: assert property (@(posedge clk) disable iff (!rst_b)
    safety_timer_half_rate |-> $past(batsw_ctrl_reg[ccrb_pkg::SLOW_BIT]))
    else $error("half rate without slow-down");
  a_vlim_floor: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 input_voltage_limit_mv >= $past(vlim_reg_mv))
    else $error("input limit below register threshold");
  a_track_off: assert property (@(posedge clk) disable iff (!rst_b)
    batsw_ctrl_reg[ccrb_pkg::TRACK_HI_BIT:ccrb_pkg::TRACK_LO_BIT] == 2'h0
      |=> input_voltage_limit_mv == $past(ccrb_pkg::VLIM_BASE_MV + ccrb_pkg::VLIM_STEP_MV
        * 16'(input_cfg_reg[ccrb_pkg::VLIM_HI_BIT:ccrb_pkg::VLIM_LO_BIT])))
    else $error("input limit off its code");

  c_detect: cover property (@(posedge clk) disable iff (!rst_b) detection_start);
  c_wdog: cover property (@(posedge clk) disable iff (!rst_b) wdog_expire);
  c_bsw_off: cover property (@(posedge clk) disable iff (!rst_b) $fell(battery_switch_on));
  c_track: cover property (@(posedge clk) disable iff (!rst_b) vlim_next != vlim_reg_mv);
endmodule : ccrb_top

// ### dv/ccrb_detect_model.sv
// Charger-core stand-in for data-line detection: ends each detection run.
// Assumes detection_start is a one-cycle pulse in the clk domain.
`timescale 1ns/100ps
module ccrb_detect_model #(
  parameter int DONE_DLY = 10
) (
  input wire logic clk,
  input wire logic detection_start,
  output logic detect_done
);
  initial begin
    detect_done = 1'b0;
    forever begin
      @(posedge clk iff detection_start === 1'b1);
      // A real detection takes a while, so the pending state is observable
      repeat (DONE_DLY) @(negedge clk);
      detect_done = 1'b1;
      @(negedge clk);
      detect_done = 1'b0;
    end
  end
endmodule : ccrb_detect_model

// ### dv/charger_control_register_bank_test.sv
// Self-checking bench for the charger control register bank.
// Assumes shortened watchdog and battery switch counts; inputs move on negedge.
`timescale 1ns/100ps
module charger_control_register_bank_test;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, soft_reg_reset = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, rdata_pin;
  logic power_select_pin = 1'b0, high_impedance_mode = 1'b0, in_input_limit = 1'b0;
  logic in_cool_band = 1'b0, in_warm_band = 1'b0, in_thermal_reg = 1'b0, detect_done;
  logic [15:0] battery_mv = 16'h0FA0, charge_voltage_mv = 16'h1068;
  logic termination_enable, input_protect_switch_off, fast_timer_enable;
  logic precharge_timer_enable, safety_timer_half_rate, thermal_regulation_threshold;
  logic cool_current_select, detection_start, detection_active, battery_switch_on;
  logic battery_switch_reset_enable, watchdog_expired;
  logic [3:0] safety_timer_hours;
  logic [1:0] input_overvoltage_threshold, boost_voltage_select;
  logic [15:0] input_voltage_limit_mv, charge_voltage_limit_mv;
  int n_mismatch = 0;
  int num_checks = 0;

  ccrb_top #(.WDOG_BASE_CYC(32'd50), .BSW_DLY_CYC(32'd20), .PSEL_VARIANT(1'b0)) dut_u (
    .clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .soft_reg_reset,
    .power_select_pin, .high_impedance_mode, .in_input_limit, .in_cool_band,
    .in_warm_band, .in_thermal_reg, .detect_done, .battery_mv, .charge_voltage_mv,
    .reg_rdata, .termination_enable, .input_protect_switch_off, .fast_timer_enable,
    .precharge_timer_enable, .safety_timer_hours, .safety_timer_half_rate,
    .thermal_regulation_threshold, .cool_current_select, .input_overvoltage_threshold,
    .boost_voltage_select, .input_voltage_limit_mv, .detection_start, .detection_active,
    .battery_switch_on, .charge_voltage_limit_mv, .battery_switch_reset_enable,
    .watchdog_expired);

  ccrb_detect_model #(.DONE_DLY(10)) det_u (.clk, .detection_start, .detect_done);

  ccrb_top #(.WDOG_BASE_CYC(32'd50), .BSW_DLY_CYC(32'd20), .PSEL_VARIANT(1'b1)) dut_pin_u (
    .clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .soft_reg_reset,
    .power_select_pin, .high_impedance_mode, .in_input_limit, .in_cool_band,
    .in_warm_band, .in_thermal_reg, .detect_done, .battery_mv, .charge_voltage_mv,
    .reg_rdata(rdata_pin), .termination_enable(), .input_protect_switch_off(),
    .fast_timer_enable(), .precharge_timer_enable(), .safety_timer_hours(),
    .safety_timer_half_rate(), .thermal_regulation_threshold(), .cool_current_select(),
    .input_overvoltage_threshold(), .boost_voltage_select(), .input_voltage_limit_mv(),
    .detection_start(), .detection_active(), .battery_switch_on(),
    .charge_voltage_limit_mv(), .battery_switch_reset_enable(), .watchdog_expired());

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check_reg

  task automatic check_out(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle

  task automatic read_all(input logic [7:0] e5, input logic [7:0] e6, input logic [7:0] e7);
    rd(8'h05, rv);
    check_reg("charge_timer_control", e5, rv);
    rd(8'h06, rv);
    check_reg("input_protection_config", e6, rv);
    rd(8'h07, rv);
    check_reg("battery_switch_control", e7, rv);
  endtask : read_all

  task automatic t_reset();
    read_all(8'h9F, 8'h66, 8'h4C);
    rd(8'h08, rv);
    check_reg("unmapped_read", 8'h00, rv);
    check_out("termination_enable", 16'h0001, termination_enable);
    check_out("fast_timer_enable", 16'h0001, fast_timer_enable);
    check_out("safety_timer_hours", 16'(ccrb_pkg::SAFE_LONG_H), safety_timer_hours);
    check_out("thermal_regulation_threshold", 16'h0001, thermal_regulation_threshold);
    check_out("cool_current_select", 16'h0001, cool_current_select);
    check_out("input_overvoltage_threshold", 16'h0001, input_overvoltage_threshold);
    check_out("boost_voltage_select", 16'h0002, boost_voltage_select);
    check_out("input_voltage_limit_mv", 16'h1194, input_voltage_limit_mv);
    check_out("battery_switch_reset_enable", 16'h0001, battery_switch_reset_enable);
  endtask : t_reset

  // Watchdog periods, then which fields the expiry and the soft reset restore
  task automatic t_watchdog();
    int n;
    int exp_n;
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h2B);
    settle();
    check_out("battery_switch_reset_enable", 16'h0000, battery_switch_reset_enable);
    for (int sel = 1; sel <= 4; sel++) begin
      wr(8'h05, 8'h8F | 8'((sel % 4) << 4));
      exp_n = (sel == 4) ? 250 : (50 << (sel - 1));
      n = 0;
      while (watchdog_expired !== 1'b1 && n < 250) begin
        @(negedge clk);
        n++;
      end
      check_out("watchdog_period_ok", 16'h0001, 16'(n >= exp_n - 3 && n <= exp_n + 3));
    end
    settle();
    read_all(8'h8F, 8'h00, 8'h6F);
    @(negedge clk);
    soft_reg_reset = 1'b1;
    @(negedge clk);
    soft_reg_reset = 1'b0;
    settle();
    read_all(8'h9F, 8'h66, 8'h4C);
    check_out("battery_switch_on", 16'h0001, battery_switch_on);
  endtask : t_watchdog

  task automatic t_ctrl();
    wr(8'h05, 8'h40);
    settle();
    check_out("termination_enable", 16'h0000, termination_enable);
    check_out("fast_timer_enable", 16'h0000, fast_timer_enable);
    check_out("precharge_timer_enable", 16'h0000, precharge_timer_enable);
    check_out("safety_timer_hours", 16'(ccrb_pkg::SAFE_SHORT_H), safety_timer_hours);
    check_out("thermal_regulation_threshold", 16'h0000, thermal_regulation_threshold);
    check_out("cool_current_select", 16'h0000, cool_current_select);
    check_out("input_protect_switch_off", 16'h0000, input_protect_switch_off);
    high_impedance_mode = 1'b1;
    settle();
    check_out("input_protect_switch_off", 16'h0001, input_protect_switch_off);
    wr(8'h05, 8'h08);
    settle();
    check_out("input_protect_switch_off", 16'h0000, input_protect_switch_off);
    check_out("precharge_timer_enable", 16'h0001, precharge_timer_enable);
    high_impedance_mode = 1'b0;
  endtask : t_ctrl

  task automatic t_vlim();
    logic [15:0] offs [4];
    logic [15:0] base;
    logic [15:0] trk;
    offs = '{16'h0000, ccrb_pkg::TRACK1_MV, ccrb_pkg::TRACK2_MV, ccrb_pkg::TRACK3_MV};
    for (int c = 0; c < 16; c += 15) begin
      for (int t = 0; t < 4; t++) begin
        wr(8'h06, 8'(c));
        wr(8'h07, 8'h4C | 8'(t));
        settle();
        base = ccrb_pkg::VLIM_BASE_MV + 16'(c) * ccrb_pkg::VLIM_STEP_MV;
        trk = (t == 0) ? 16'h0000 : battery_mv + offs[t];
        check_out("input_voltage_limit_mv", (trk > base) ? trk : base,
                  input_voltage_limit_mv);
      end
    end
    wr(8'h07, 8'h4C);
  endtask : t_vlim

  task automatic t_detect();
    wr(8'h07, 8'hCC);
    check_out("detection_start", 16'h0001, detection_start);
    @(negedge clk);
    check_out("detection_active", 16'h0001, detection_active);
    rd(8'h07, rv);
    check_reg("battery_switch_control", 8'hCC, rv);
    repeat (20) @(negedge clk);
    check_out("detection_active", 16'h0000, detection_active);
    rd(8'h07, rv);
    check_reg("battery_switch_control", 8'h4C, rv);
  endtask : t_detect

  task automatic t_bsw();
    wr(8'h07, 8'h64);
    repeat (2) @(negedge clk);
    check_out("battery_switch_on", 16'h0000, battery_switch_on);
    wr(8'h07, 8'h4C);
    settle();
    check_out("battery_switch_on", 16'h0001, battery_switch_on);
    wr(8'h07, 8'h6C);
    repeat (10) @(negedge clk);
    check_out("battery_switch_on", 16'h0001, battery_switch_on);
    repeat (20) @(negedge clk);
    check_out("battery_switch_on", 16'h0000, battery_switch_on);
    wr(8'h07, 8'h4C);
  endtask : t_bsw

  task automatic t_band();
    in_warm_band = 1'b1;
    settle();
    check_out("charge_voltage_limit_mv", ccrb_pkg::WARM_MAX_MV, charge_voltage_limit_mv);
    wr(8'h07, 8'h5C);
    settle();
    check_out("charge_voltage_limit_mv", charge_voltage_mv, charge_voltage_limit_mv);
    in_warm_band = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {in_input_limit, in_cool_band, in_thermal_reg} = 3'h1 << i;
      wr(8'h07, 8'h4C);
      settle();
      check_out("safety_timer_half_rate", 16'h0001, safety_timer_half_rate);
      wr(8'h07, 8'h0C);
      settle();
      check_out("safety_timer_half_rate", 16'h0000, safety_timer_half_rate);
    end
    {in_input_limit, in_cool_band, in_thermal_reg} = 3'h0;
  endtask : t_band

  task automatic t_pin();
    power_select_pin = 1'b1;
    settle();
    rd(8'h07, rv);
    check_reg("battery_switch_control", 8'h0C, rv);
    check_reg("battery_switch_control_pin", 8'h8C, rdata_pin);
    power_select_pin = 1'b0;
    settle();
    rd(8'h07, rv);
    check_reg("battery_switch_control_pin", 8'h0C, rdata_pin);
  endtask : t_pin

  task automatic summarize();
    $display("mismatches %0d, checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Whole run needs under 2000 cycles
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    $display("unexpected timeout: expected completion, seen hang");
    summarize();
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_watchdog();
    // Soft reset re-enables the watchdog; t_ctrl's first write turns it off for the rest, so expiry cannot disturb later scenarios
    t_ctrl();
    t_vlim();
    t_detect();
    t_bsw();
    t_band();
    t_pin();
    summarize();
  end
endmodule : charger_control_register_bank_test
